// [hw/tcw_top.sv]
// timer16 control, waveform configuration and register slave
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/10ps
module tcw_top
   import tcw_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              rst_n_i,
   input  wire logic              ce_i,
   input  wire logic [1:0]        sleep_mode_i,
   input  wire logic [ADDR_W+1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [31:0]       writedata,
   input  wire logic [3:0]        byteenable,
   output logic [31:0]            readdata,
   output logic                   waitrequest,
   output logic                   irq_o,
   output tcw_wave_t              wave_o
);
   logic [7:0]     reg_clk_en;
   logic [7:0]     reg_wave;
   logic [7:0]     reg_force;
   logic           update_lock;
   logic [15:0]    period;
   logic [15:0]    cmp     [NCH];
   logic [15:0]    cmp_buf [NCH];
   logic [NCH-1:0] buf_valid;
   logic [15:0]    count;
   logic           count_down;
   logic [NCH-1:0] level;
   logic [1:0]     status;
   logic [1:0]     mask;
   logic           acked;
   logic [1:0]     sleep_s1;
   logic [1:0]     sleep_s2;
   logic           tick;
   logic           halted;
   logic           running;
   logic           sel_ok;
   logic           wr_stb;
   logic           rd_stb;
   logic [ADDR_W-1:0] idx;
   logic [2:0]     wmode;
   logic           auto_lock;
   logic [NCH-1:0] out_en;
   logic [15:0]    top_val;
   logic           at_top;
   logic           at_bottom;
   logic           upd_cond;
   logic           ovf_cond;
   logic           sw_update;
   logic           do_copy;
   logic [NCH-1:0] buf_wr;
   logic           all_valid;
   logic           dual;
   logic [31:0]    next_readdata;

   assign idx       = address[ADDR_W+1:2];
   // writes land at the edge that accepts them; read data is latched one edge
   // earlier so that it already stands while waitrequest is low
   assign wr_stb    = write && acked;
   assign rd_stb    = read && !acked;
   assign wmode     = reg_wave[WM_LSB +: 3];
   assign auto_lock = reg_wave[AL_BIT];
   assign out_en    = reg_wave[CE_LSB +: NCH];
   assign dual      = (wmode == WM_DTOP) || (wmode == WM_DBOTH) || (wmode == WM_DLOW);

   // one wait cycle on every access, answer on the second edge
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acked <= 1'b0;
      end else if (ce_i) begin
         acked <= (read || write) && !acked;
      end
   end
   assign waitrequest = (read || write) && !(acked && ce_i);

   // sleep request comes from another domain
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sleep_s1 <= 2'h0;
         sleep_s2 <= 2'h0;
      end else if (ce_i) begin
         sleep_s1 <= sleep_mode_i;
         sleep_s2 <= sleep_s1;
      end
   end

   always_comb begin
      case (tcw_sleep_t'(sleep_s2))
         TCW_STANDBY:   halted = !reg_clk_en[RS_BIT];
         TCW_POWERDOWN: halted = 1'b1;
         default:       halted = 1'b0;
      endcase
   end

   // timer runs only with the enable bit, and not in power-down, nor in standby unless RS_BIT is set
   assign running = reg_clk_en[EN_BIT] && !halted;

   tcw_prescaler u_prescaler (
      .clock_i  (clock_i),
      .rst_n_i  (rst_n_i),
      .ce_i     (ce_i),
      .run_i    (running),
      .select_i (reg_clk_en[PS_LSB +: 3]),
      .tick_o   (tick)
   );

   // TOP source and UPDATE / overflow points per mode
   assign top_val   = (wmode == WM_FREQ) ? cmp[0] : period;
   assign at_top    = (count == top_val);
   assign at_bottom = (count == 16'h0000);
   always_comb begin
      case (wmode)
         WM_NORMAL, WM_FREQ: begin
            upd_cond = at_top && !count_down;
            ovf_cond = at_top && !count_down;
         end
         WM_SINGLE, WM_DLOW: begin
            upd_cond = at_bottom && count_down == dual;
            ovf_cond = upd_cond;
         end
         WM_DTOP: begin
            upd_cond = at_bottom && count_down;
            ovf_cond = at_top && !count_down;
         end
         WM_DBOTH: begin
            upd_cond = at_bottom && count_down;
            ovf_cond = (at_top && !count_down) || upd_cond;
         end
         default: begin
            upd_cond = 1'b0;
            ovf_cond = 1'b0;
         end
      endcase
   end

   // single slope wraps at TOP; dual slope turns round
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count      <= 16'h0000;
         count_down <= 1'b0;
      end else if (ce_i && tick) begin
         if (dual) begin
            if (!count_down && at_top) begin
               count_down <= 1'b1;
               count      <= count - 16'h0001;
            end else if (count_down && at_bottom) begin
               count_down <= 1'b0;
               count      <= count + 16'h0001;
            end else if (count_down) begin
               count <= count - 16'h0001;
            end else begin
               count <= count + 16'h0001;
            end
         end else begin
            count_down <= 1'b0;
            count      <= at_top ? 16'h0000 : count + 16'h0001;
         end
      end
   end

   assign sw_update = wr_stb && (idx == IDX_CMD) && byteenable[0]
                      && (writedata[CMD_LSB +: 2] == CMD_UPDATE);
   // the hardware UPDATE obeys the lock, the command does not
   assign do_copy = (tick && upd_cond && !update_lock) || sw_update;

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_cmp
         assign buf_wr[g] = wr_stb && (idx == IDX_CMPBUF0 + ADDR_W'(g));
         always_ff @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               cmp[g]       <= 16'h0000;
               cmp_buf[g]   <= 16'h0000;
               buf_valid[g] <= 1'b0;
            end else if (ce_i) begin
               if (buf_wr[g]) begin
                  if (byteenable[0]) cmp_buf[g][7:0]  <= writedata[7:0];
                  if (byteenable[1]) cmp_buf[g][15:8] <= writedata[15:8];
               end
               if (wr_stb && idx == IDX_CMP0 + ADDR_W'(g)) begin
                  if (byteenable[0]) cmp[g][7:0]  <= writedata[7:0];
                  if (byteenable[1]) cmp[g][15:8] <= writedata[15:8];
               end else if (do_copy) begin
                  cmp[g] <= cmp_buf[g];
               end
               // a write sets valid, winning over the UPDATE clear
               if (buf_wr[g]) begin
                  buf_valid[g] <= 1'b1;
               end else if (do_copy || (tick && upd_cond)) begin
                  buf_valid[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   assign all_valid = ((buf_valid | ~out_en) == {NCH{1'b1}});

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         update_lock <= 1'b0;
      end else if (ce_i) begin
         if (wr_stb && idx == IDX_LOCK && byteenable[0]) begin
            update_lock <= writedata[0];
         end else if (auto_lock) begin
            // set by every copy and held while any enabled buffer is stale
            if (do_copy || !all_valid) begin
               update_lock <= 1'b1;
            end else begin
               update_lock <= 1'b0;
            end
         end
      end
   end

   // compare matches drive levels while running; forced values while the enable bit is clear
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level <= {NCH{1'b0}};
      end else if (ce_i) begin
         if (!reg_clk_en[EN_BIT]) begin
            level <= reg_force[NCH-1:0];
         end else if (tick) begin
            for (int i = 0; i < NCH; i++) begin
               if (wmode == WM_FREQ) begin
                  if (i == 0 && at_top) level[i] <= ~level[i];
               end else if (count == cmp[i]) begin
                  level[i] <= dual ? !count_down : 1'b0;
               end else if (!dual && at_bottom) begin
                  level[i] <= 1'b1;
               end
            end
         end
      end
   end

   // pin direction stays with the port logic outside this block
   tcw_wave_gate #(.N(NCH)) u_gate (
      .level_i   (level),
      .out_en_i  (out_en),
      .wave_on_i (wmode != WM_NORMAL || !reg_clk_en[EN_BIT]),
      .wave_o    (wave_o)
   );

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_clk_en <= RST_BYTE;
         reg_wave   <= RST_BYTE;
         reg_force  <= RST_BYTE;
         period     <= 16'hffff;
      end else if (ce_i && wr_stb) begin
         if (idx == IDX_CLK_EN && byteenable[0]) reg_clk_en <= writedata[7:0];
         if (idx == IDX_WAVE && byteenable[0]) reg_wave <= writedata[7:0];
         if (idx == IDX_FORCE && byteenable[0]) reg_force <= writedata[7:0];
         if (idx == IDX_PERIOD && byteenable[0]) period[7:0] <= writedata[7:0];
         if (idx == IDX_PERIOD && byteenable[1]) period[15:8] <= writedata[15:8];
      end
   end

   // sticky events, cleared by a status read; a new event wins over the clear
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status <= 2'h0;
         mask   <= 2'h0;
      end else if (ce_i) begin
         status <= (rd_stb && idx == IDX_STATUS ? 2'h0 : status)
                   | {do_copy, tick && ovf_cond};
         if (wr_stb && idx == IDX_MASK && byteenable[0]) mask <= writedata[1:0];
      end
   end
   assign irq_o = |(status & mask);

   always_comb begin
      next_readdata = 32'h0000_0000;
      case (idx)
         IDX_CLK_EN: next_readdata[7:0]  = {reg_clk_en[7], 3'h0, reg_clk_en[3:0]};
         IDX_WAVE:   next_readdata[7:0]  = {1'b0, reg_wave[6:0]};
         IDX_FORCE:  next_readdata[7:0]  = {5'h00, reg_force[2:0]};
         IDX_LOCK:   next_readdata[7:0]  = {4'h0, buf_valid, update_lock};
         IDX_PERIOD: next_readdata[15:0] = period;
         IDX_STATUS: next_readdata[1:0]  = status;
         IDX_MASK:   next_readdata[1:0]  = mask;
         IDX_COUNT:  next_readdata[16:0] = {count_down, count};
         default: begin
            for (int i = 0; i < NCH; i++) begin
               if (idx == IDX_CMP0 + ADDR_W'(i)) next_readdata[15:0] = cmp[i];
               if (idx == IDX_CMPBUF0 + ADDR_W'(i)) next_readdata[15:0] = cmp_buf[i];
            end
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         readdata <= 32'h0000_0000;
      end else if (ce_i && rd_stb) begin
         readdata <= next_readdata;
      end
   end
endmodule

// [include/tcw_pkg.sv]
// package: register map, field layout and types of the timer16 control block
package tcw_pkg;
   localparam int ADDR_W = 4;
   localparam int NCH    = 3;
   // registers are word aligned, so byte address = 4 * index
   localparam logic [ADDR_W-1:0] IDX_CLK_EN   = 4'h0;
   localparam logic [ADDR_W-1:0] IDX_WAVE     = 4'h1;
   localparam logic [ADDR_W-1:0] IDX_FORCE    = 4'h2;
   localparam logic [ADDR_W-1:0] IDX_LOCK     = 4'h3;
   localparam logic [ADDR_W-1:0] IDX_PERIOD   = 4'h4;
   localparam logic [ADDR_W-1:0] IDX_CMP0     = 4'h5;
   localparam logic [ADDR_W-1:0] IDX_CMPBUF0  = 4'h8;
   localparam logic [ADDR_W-1:0] IDX_CMD      = 4'hb;
   localparam logic [ADDR_W-1:0] IDX_STATUS   = 4'hc;
   localparam logic [ADDR_W-1:0] IDX_MASK     = 4'hd;
   localparam logic [ADDR_W-1:0] IDX_COUNT    = 4'he;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam int EN_BIT = 0;
   localparam int PS_LSB = 1;
   localparam int RS_BIT = 7;
   localparam int WM_LSB = 0;
   localparam int AL_BIT = 3;
   localparam int CE_LSB = 4;
   localparam logic [2:0] WM_NORMAL = 3'h0;
   localparam logic [2:0] WM_FREQ   = 3'h1;
   localparam logic [2:0] WM_SINGLE = 3'h3;
   localparam logic [2:0] WM_DTOP   = 3'h5;
   localparam logic [2:0] WM_DBOTH  = 3'h6;
   localparam logic [2:0] WM_DLOW   = 3'h7;
   localparam logic [1:0] CMD_UPDATE = 2'h1;
   localparam int CMD_LSB = 0;
   // status bits: overflow, update done
   localparam int ST_OVF = 0;
   localparam int ST_UPD = 1;

   typedef enum logic [1:0] {TCW_ACTIVE, TCW_STANDBY, TCW_POWERDOWN, TCW_IDLE} tcw_sleep_t;

   typedef struct packed {
      logic [NCH-1:0] pad_value;
      logic [NCH-1:0] pad_override;
      logic [NCH-1:0] logic_value;
   } tcw_wave_t;
endpackage

// [hw/tcw_prescaler.sv]
// prescaler: single-cycle count tick at the selected division
`timescale 1ns/10ps
module tcw_prescaler
   import tcw_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   input  wire logic       ce_i,
   input  wire logic       run_i,
   input  wire logic [2:0] select_i,
   output logic            tick_o
);
   logic [9:0] div_cnt;
   logic [9:0] mask;

   always_comb begin
      case (select_i)
         3'h0:    mask = 10'h000;
         3'h1:    mask = 10'h001;
         3'h2:    mask = 10'h003;
         3'h3:    mask = 10'h007;
         3'h4:    mask = 10'h00f;
         3'h5:    mask = 10'h03f;
         3'h6:    mask = 10'h0ff;
         default: mask = 10'h3ff;
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_cnt <= 10'h000;
      end else if (ce_i) begin
         if (!run_i) begin
            div_cnt <= 10'h000;
         end else begin
            div_cnt <= div_cnt + 10'h001;
         end
      end
   end

   // tick when the low bits roll over
   assign tick_o = run_i && ce_i && ((div_cnt & mask) == mask);
endmodule

// [hw/tcw_wave_gate.sv]
// per-channel routing of waveform levels to pads and to the logic block
`timescale 1ns/10ps
module tcw_wave_gate
   import tcw_pkg::*;
#(
   parameter int N = NCH
) (
   input  wire logic [N-1:0] level_i,
   input  wire logic [N-1:0] out_en_i,
   input  wire logic         wave_on_i,
   output tcw_wave_t         wave_o
);
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ch
         // pads gated by enable; logic block path is not
         assign wave_o.pad_override[g] = out_en_i[g] && wave_on_i;
         assign wave_o.pad_value[g]    = level_i[g];
         assign wave_o.logic_value[g]  = level_i[g];
      end
   endgenerate
endmodule

// [tb/tcw_pin_model.sv]
// model of the port pins and the logic block fed by the timer waveforms
`timescale 1ns/10ps
module tcw_pin_model
   import tcw_pkg::*;
(
   input  wire logic [NCH-1:0] port_out_i,
   input  wire logic [NCH-1:0] port_dir_i,
   input  wire tcw_wave_t      wave_i,
   output logic      [NCH-1:0] pin_o,
   output logic      [NCH-1:0] clb_o
);
   always_comb begin
      for (int n = 0; n < NCH; n++) begin
         // an input pin floats to its pull-up; only the port sets direction
         if (!port_dir_i[n])
            pin_o[n] = 1'b1;
         else if (wave_i.pad_override[n])
            pin_o[n] = wave_i.pad_value[n];
         else
            pin_o[n] = port_out_i[n];
      end
   end
   // the logic-block path ignores the output enables
   assign clb_o = wave_i.logic_value;
endmodule

// [tb/tcw_top_asserts.sv]
// checker: bus handshake, waveform routing and update lock of the timer16 control
`timescale 1ns/10ps
module tcw_top_asserts
   import tcw_pkg::*;
(
   input wire logic              clock_i,
   input wire logic              rst_n_i,
   input wire logic              ce_i,
   input wire logic [1:0]        sleep_mode_i,
   input wire logic [ADDR_W+1:0] address,
   input wire logic              read,
   input wire logic              write,
   input wire logic [31:0]       writedata,
   input wire logic [3:0]        byteenable,
   input wire logic [31:0]       readdata,
   input wire logic              waitrequest,
   input wire logic              irq_o,
   input wire tcw_wave_t         wave_o
);
   logic [7:0] clk_en, wave, force_v, mask;
   logic       lock, lock_known, wr_done, rd_lock;
   assign wr_done = write && !waitrequest && byteenable[0];
   assign rd_lock = read && !waitrequest && address[5:2] == IDX_LOCK;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // shadows let routing be judged from bus traffic alone
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk_en <= RST_BYTE;
         wave <= RST_BYTE;
         force_v <= RST_BYTE;
         mask <= RST_BYTE;
         lock <= 1'b0;
      end else if (wr_done) begin
         case (address[5:2])
            IDX_CLK_EN: clk_en <= writedata[7:0];
            IDX_WAVE:   wave <= writedata[7:0];
            IDX_FORCE:  force_v <= writedata[7:0];
            IDX_MASK:   mask <= writedata[7:0];
            IDX_LOCK:   lock <= writedata[0];
            default:    lock <= lock;
         endcase
      end
   end
   // once auto-lock has run, the lock is unknown until software writes it with auto-lock off
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i)
         lock_known <= 1'b1;
      else if (wave[AL_BIT])
         lock_known <= 1'b0;
      else if (wr_done && address[5:2] == IDX_LOCK)
         lock_known <= 1'b1;
   end
   one_wait_a: assert property ((read || write) && waitrequest && ce_i |=> !waitrequest || !ce_i)
      else $error("request not answered after one wait state");
   idle_nowait_a: assert property (!read && !write |-> !waitrequest)
      else $error("waitrequest high without a request");
   bus_stall_a: assert property ((read || write) && !ce_i && !$past(ce_i) |-> waitrequest)
      else $error("request answered while clock enable low");
   pad_level_a: assert property (wave_o.pad_value == wave_o.logic_value)
      else $error("pad and logic-block levels differ");
   pad_override_a: assert property (wave_o.pad_override == (wave[6:4] &
      {3{wave[2:0] != WM_NORMAL || !clk_en[EN_BIT]}})) else $error("pad override wrong");
   force_level_a: assert property (!clk_en[EN_BIT] && !$past(clk_en[EN_BIT]) &&
      $stable(force_v) |-> wave_o.logic_value == force_v[2:0]) else $error("forced level wrong");
   lock_hold_a: assert property (rd_lock && lock_known |-> readdata[0] == lock)
      else $error("update lock changed without software");
   auto_lock_a: assert property (rd_lock && wave[AL_BIT] && $past(wave[AL_BIT]) &&
      wave[6:4] != 3'h0 |-> readdata[0] == !(&(readdata[3:1] | ~wave[6:4])))
      else $error("auto lock does not follow buffer valid flags");
   irq_mask_a: assert property (irq_o |-> mask != 8'h00)
      else $error("interrupt raised while fully masked");
endmodule
bind tcw_top tcw_top_asserts tcw_top_asserts_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .ce_i(ce_i), .sleep_mode_i(sleep_mode_i), .address(address), .read(read), .write(write),
   .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
   .waitrequest(waitrequest), .irq_o(irq_o), .wave_o(wave_o));

// [tb/tcw_top_bench.sv]
// self-checking bench for the timer16 control block
`timescale 1ns/10ps
module tcw_top_bench
   import tcw_pkg::*;
   ;
   localparam int         SHIFT [8] = '{0, 1, 2, 3, 4, 6, 8, 10};
   localparam logic [2:0] MODES [6] = '{WM_NORMAL, WM_FREQ, WM_SINGLE, WM_DTOP, WM_DBOTH, WM_DLOW};
   logic              clock_i = 1'b0;
   logic              rst_n_i = 1'b0;
   logic              ce_i = 1'b1;
   logic [1:0]        sleep_mode_i = 2'h0;
   logic [ADDR_W+1:0] address = '0;
   logic              read = 1'b0;
   logic              write = 1'b0;
   logic [31:0]       writedata = '0;
   logic [3:0]        byteenable = 4'h0;
   logic [31:0]       readdata, rd, v;
   logic              waitrequest, irq_o;
   tcw_wave_t         wave_o;
   logic [NCH-1:0]    port_dir = 3'h7;
   logic [NCH-1:0]    pin, clb;
   int                bad_count = 0;
   int                comparisons = 0;
   always #10 clock_i = ~clock_i;
   tcw_top tcw_top_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .sleep_mode_i(sleep_mode_i), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .irq_o(irq_o), .wave_o(wave_o));
   tcw_pin_model tcw_pin_model_i (.port_out_i(3'h0), .port_dir_i(port_dir), .wave_i(wave_o),
      .pin_o(pin), .clb_o(clb));
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         bad_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   // one edge always passes before a request rises, so no signal is driven twice at once
   task automatic bus(input logic [3:0] idx, input logic wr, input logic [15:0] wd);
      int n;
      @(posedge clock_i);
      address <= {idx, 2'b00};
      writedata <= {16'h0000, wd};
      byteenable <= 4'h3;
      write <= wr;
      read <= ~wr;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (waitrequest !== 1'b0 && n < 200);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 200) begin
         bad_count++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [3:0] idx, input logic [15:0] d);
      bus(idx, 1'b1, d);
   endtask
   task automatic rchk(input logic [3:0] idx, input logic [31:0] want);
      bus(idx, 1'b0, 16'h0000);
      check(rd, want);
   endtask
   task automatic settle();
      repeat (3) @(posedge clock_i);
      #1;
   endtask
   // two count reads whose capture edges lie gap+3 cycles apart
   task automatic delta(input int gap, input logic [31:0] want);
      logic [15:0] c0;
      bus(IDX_COUNT, 1'b0, 16'h0000);
      c0 = rd[15:0];
      repeat (gap) @(posedge clock_i);
      bus(IDX_COUNT, 1'b0, 16'h0000);
      check({16'h0000, rd[15:0] - c0}, want);
   endtask
   initial begin
      repeat (10) @(posedge clock_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 3; i++) rchk(4'(i), 32'h0);
      wr(4'hf, 16'h00ff);
      rchk(4'hf, 32'h0);
      ce_i <= 1'b0;
      fork
         wr(IDX_MASK, 16'h0000);
         begin
            repeat (6) @(posedge clock_i);
            check({31'h0, waitrequest}, 32'h1);
            ce_i <= 1'b1;
         end
      join
      $display("test reset_map done");
      for (int s = 0; s < 8; s++) begin
         wr(IDX_CLK_EN, 16'((s << PS_LSB) | 1));
         delta(2045, 32'(2048 >> SHIFT[s]));
      end
      wr(IDX_CLK_EN, 16'h0001);
      sleep_mode_i <= 2'h1;
      repeat (4) @(posedge clock_i);
      delta(29, 32'h0);
      wr(IDX_CLK_EN, 16'h0081);
      delta(29, 32'h20);
      sleep_mode_i <= 2'h2;
      repeat (4) @(posedge clock_i);
      delta(29, 32'h0);
      sleep_mode_i <= 2'h0;
      wr(IDX_CLK_EN, 16'h0000);
      delta(29, 32'h0);
      $display("test prescale_sleep done");
      wr(IDX_FORCE, 16'h0006);
      wr(IDX_WAVE, 16'h0050);
      settle();
      check(32'(wave_o), 32'h1ae);
      check({26'h0, pin, clb}, 32'h26);
      wr(IDX_CLK_EN, 16'h000f);
      foreach (MODES[k]) begin
         wr(IDX_WAVE, 16'h0050 | 16'(MODES[k]));
         settle();
         check(32'(wave_o.pad_override), MODES[k] == WM_NORMAL ? 32'h0 : 32'h5);
      end
      wr(IDX_CLK_EN, 16'h0000);
      port_dir <= 3'h0;
      settle();
      check(32'(pin), 32'h7);
      $display("test waveform done");
      // second reset: the count restarts at zero so the short period is reached
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      wr(IDX_PERIOD, 16'h0010);
      wr(IDX_WAVE, 16'h003b);
      rchk(IDX_LOCK, 32'h1);
      wr(IDX_CMPBUF0, 16'h1234);
      rchk(IDX_LOCK, 32'h3);
      wr(IDX_CMPBUF0 + 4'h1, 16'h5678);
      rchk(IDX_LOCK, 32'h6);
      wr(IDX_CLK_EN, 16'h0001);
      repeat (40) @(posedge clock_i);
      wr(IDX_CLK_EN, 16'h0000);
      rchk(IDX_LOCK, 32'h1);
      rchk(IDX_CMP0, 32'h1234);
      rchk(IDX_CMP0 + 4'h1, 32'h5678);
      wr(IDX_WAVE, 16'h0043);
      wr(IDX_LOCK, 16'h0001);
      bus(IDX_CMP0 + 4'h2, 1'b0, 16'h0000);
      v = rd;
      wr(IDX_CMPBUF0 + 4'h2, 16'h0abc);
      wr(IDX_CLK_EN, 16'h0001);
      repeat (40) @(posedge clock_i);
      wr(IDX_CLK_EN, 16'h0000);
      rchk(IDX_CMP0 + 4'h2, v);
      rchk(IDX_LOCK, 32'h1);
      wr(IDX_CMD, 16'(CMD_UPDATE));
      rchk(IDX_CMP0 + 4'h2, 32'h0abc);
      rchk(IDX_LOCK, 32'h1);
      $display("test lock_update done");
      wr(IDX_CLK_EN, 16'h0001);
      repeat (40) @(posedge clock_i);
      wr(IDX_CLK_EN, 16'h0000);
      settle();
      check({31'h0, irq_o}, 32'h0);
      wr(IDX_MASK, 16'h0001);
      settle();
      check({31'h0, irq_o}, 32'h1);
      bus(IDX_STATUS, 1'b0, 16'h0000);
      check({30'h0, rd[ST_UPD], rd[ST_OVF]}, 32'h3);
      settle();
      check({31'h0, irq_o}, 32'h0);
      $display("test interrupt done");
      stop_test();
   end
endmodule
